// ===== core/crxf_top.sv
`timescale 1ns/1ps
`default_nettype none
module crxf_top #(
  parameter int FIFO_DEPTH = crxf_pkg::CRXF_FIFO_DEPTH,
  parameter int GLITCH_LEN = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic rf_input_one,
  input wire logic rf_input_two,
  input wire logic [2:0] strength_main,
  input wire logic [2:0] strength_aux,
  input wire logic tx_done,
  input wire logic slot_start,
  input wire logic frame_sof,
  input wire logic frame_eof,
  input wire logic frame_bit,
  output logic main_rx_out,
  output logic aux_rx_out,
  output logic [3:0] band_select,
  output logic [1:0] gain_reduce,
  output logic irq
);
  import crxf_pkg::*;

  //----------------------------------------------------------------------------
  // registers
  //----------------------------------------------------------------------------
  logic [7:0] chip_state_q;
  logic [7:0] protocol_q;
  logic [7:0] no_resp_q;
  logic [7:0] rx_wait_q;
  logic [7:0] filter_q;
  logic [7:0] irq_flags_q;
  logic [7:0] coll_high_q;
  logic [7:0] coll_low_q;
  logic [7:0] strength_q;
  logic [7:0] fifo [FIFO_DEPTH];
  logic [3:0] wr_ptr_q;
  logic [3:0] rd_ptr_q;
  logic [4:0] count_q;
  logic ack_q;

  logic wr_access;
  logic rd_access;
  logic protocol_wr;
  logic type_b;
  assign wr_access = avs_write && !ack_q;
  assign rd_access = avs_read && !ack_q;
  assign protocol_wr = wr_access && avs_address == CRXF_ADDR_PROTOCOL;
  assign type_b = avs_writedata[CRXF_BIT_TYPE_B];

  // wrap a fifo pointer
  function automatic logic [3:0] ptr_inc(input logic [3:0] p);
    if (p == 4'(FIFO_DEPTH - 1))
      ptr_inc = 4'h0;
    else
      ptr_inc = p + 4'h1;
  endfunction

  //----------------------------------------------------------------------------
  // input routing
  //----------------------------------------------------------------------------
  // swap mux; only main path feeds the decoder
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      main_rx_out <= 1'b0;
      aux_rx_out <= 1'b0;
    end
    else
    begin
      main_rx_out <= chip_state_q[CRXF_BIT_SWAP] ? rf_input_two
                                                 : rf_input_one;
      aux_rx_out <= chip_state_q[CRXF_BIT_SWAP] ? rf_input_one
                                                : rf_input_two;
    end
  end

  //----------------------------------------------------------------------------
  // bus slave: one wait cycle per access
  //----------------------------------------------------------------------------
  // acknowledge toggles so every access sees one waitrequest cycle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ack_q <= 1'b0;
    else
      ack_q <= (avs_read || avs_write) && !ack_q;
  end

  // waitrequest is high while a request waits for its acknowledge
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      avs_waitrequest <= 1'b1;
    else
      avs_waitrequest <= !((avs_read || avs_write) && !ack_q);
  end

  // plain control registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      chip_state_q <= CRXF_RST_CHIP_STATE;
      protocol_q <= CRXF_RST_PROTOCOL;
    end
    else if (wr_access)
    begin
      if (avs_address == CRXF_ADDR_CHIP_STATE)
        chip_state_q <= avs_writedata[7:0];
      if (avs_address == CRXF_ADDR_PROTOCOL)
        protocol_q <= avs_writedata[7:0];
    end
  end

  // protocol writes reload presets; later writes fine-tune
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      filter_q <= CRXF_PRE_A_FILTER;
      rx_wait_q <= CRXF_PRE_A_RX_WAIT;
      no_resp_q <= CRXF_PRE_A_NO_RESP;
    end
    else if (protocol_wr)
    begin
      filter_q <= type_b ? CRXF_PRE_B_FILTER : CRXF_PRE_A_FILTER;
      rx_wait_q <= type_b ? CRXF_PRE_B_RX_WAIT
                          : CRXF_PRE_A_RX_WAIT;
      no_resp_q <= type_b ? CRXF_PRE_B_NO_RESP
                          : CRXF_PRE_A_NO_RESP;
    end
    else if (wr_access)
    begin
      if (avs_address == CRXF_ADDR_FILTER_GAIN)
        filter_q <= {avs_writedata[7:2], CRXF_RESERVED_MASK};
      if (avs_address == CRXF_ADDR_RX_WAIT)
        rx_wait_q <= avs_writedata[7:0];
      if (avs_address == CRXF_ADDR_NO_RESP)
        no_resp_q <= avs_writedata[7:0];
    end
  end

  // filter and gain outputs
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      band_select <= 4'h0;
      gain_reduce <= 2'h0;
    end
    else
    begin
      band_select <= filter_q[7:4];
      gain_reduce <= filter_q[3:2];
    end
  end

  //----------------------------------------------------------------------------
  // receive-wait and no-response timers
  //----------------------------------------------------------------------------
  logic [15:0] wait_cyc_q;
  logic [7:0] wait_units_q;
  logic hold_q;
  logic [15:0] nr_cyc_q;
  logic [7:0] nr_units_q;
  logic nr_run_q;
  logic nr_expire;

  // decoders held in reset for rx_wait units after transmit
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hold_q <= 1'b0;
      wait_cyc_q <= 16'h0000;
      wait_units_q <= 8'h00;
    end
    else if (tx_done)
    begin
      hold_q <= rx_wait_q != 8'h00;
      wait_cyc_q <= 16'h0000;
      wait_units_q <= rx_wait_q;
    end
    else if (hold_q)
    begin
      if (wait_cyc_q == 16'(CRXF_RX_WAIT_CYC - 1))
      begin
        wait_cyc_q <= 16'h0000;
        wait_units_q <= wait_units_q - 8'h01;
        if (wait_units_q == 8'h01)
          hold_q <= 1'b0;
      end
      else
        wait_cyc_q <= wait_cyc_q + 16'h0001;
    end
  end

  // no-response timer from slot start until sof
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      nr_run_q <= 1'b0;
      nr_cyc_q <= 16'h0000;
      nr_units_q <= 8'h00;
    end
    else if (slot_start)
    begin
      nr_run_q <= 1'b1;
      nr_cyc_q <= 16'h0000;
      nr_units_q <= no_resp_q;
    end
    else if (nr_run_q)
    begin
      if (frame_sof && !hold_q)
        nr_run_q <= 1'b0;
      else if (nr_expire)
        nr_run_q <= 1'b0;
      else if (nr_cyc_q == 16'(CRXF_NO_RESP_CYC - 1))
      begin
        nr_cyc_q <= 16'h0000;
        nr_units_q <= nr_units_q - 8'h01;
      end
      else
        nr_cyc_q <= nr_cyc_q + 16'h0001;
    end
  end
  assign nr_expire = nr_run_q && nr_units_q == 8'h00;

  //----------------------------------------------------------------------------
  // bit decoder: glitch filter on main path
  //----------------------------------------------------------------------------
  logic [GLITCH_LEN-1:0] hist_q;
  logic bit_q;
  logic bit_clk_q;
  logic armed_q;

  // a level must persist GLITCH_LEN samples before it is taken
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hist_q <= '0;
      bit_q <= 1'b0;
      bit_clk_q <= 1'b0;
      armed_q <= 1'b0;
    end
    else if (hold_q)
    begin
      hist_q <= '0;
      bit_clk_q <= 1'b0;
      armed_q <= 1'b0;
    end
    else
    begin
      hist_q <= {hist_q[GLITCH_LEN-2:0], frame_bit};
      bit_clk_q <= 1'b0;
      if (frame_sof)
        armed_q <= 1'b0; // line noise before sof is no bit
      else if (!(&hist_q || ~|hist_q))
        armed_q <= 1'b1; // a change arms exactly one strobe
      else if (armed_q)
      begin
        bit_q <= hist_q[0];
        bit_clk_q <= 1'b1;
        armed_q <= 1'b0;
      end
    end
  end

  //----------------------------------------------------------------------------
  // framer: 8 data bits plus parity, crc check, fifo write
  //----------------------------------------------------------------------------
  typedef enum logic [1:0] {CRXF_IDLE, CRXF_DATA, CRXF_PARITY} crxf_state_e;
  crxf_state_e state_q;
  logic [2:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic [9:0] pos_q;
  logic [15:0] crc_q;
  logic [7:0] pend_q [2];
  logic [1:0] pend_cnt_q;
  logic push;
  logic [7:0] push_data;
  logic pop;
  logic sof_ok;
  logic eof_ok;
  logic par_err;
  logic coll_hit;

  // crc byte update, reflected 0x8408 polynomial
  function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                           input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++)
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ 16'h8408) : (r >> 1);
    crc_byte = r;
  endfunction

  assign sof_ok = frame_sof && !frame_eof && !hold_q;
  assign eof_ok = frame_eof && !frame_sof && !hold_q
                  && state_q != CRXF_IDLE;
  assign par_err = bit_clk_q && state_q == CRXF_PARITY
                   && bit_q == ^shift_q;
  assign coll_hit = frame_sof && frame_eof && state_q != CRXF_IDLE;
  assign pop = rd_access && avs_address == CRXF_ADDR_FIFO_DATA
               && count_q != 5'h00;

  // bytes delayed by two so the crc bytes are never pushed
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= CRXF_IDLE;
      bit_cnt_q <= 3'h0;
      shift_q <= 8'h00;
      pos_q <= 10'h000;
      crc_q <= 16'hFFFF;
      pend_cnt_q <= 2'h0;
      pend_q[0] <= 8'h00;
      pend_q[1] <= 8'h00;
    end
    else if (sof_ok)
    begin
      state_q <= CRXF_DATA;
      bit_cnt_q <= 3'h0;
      pos_q <= 10'h000;
      crc_q <= 16'hFFFF;
      pend_cnt_q <= 2'h0;
    end
    else if (eof_ok)
      state_q <= CRXF_IDLE;
    else if (bit_clk_q)
    begin
      if (state_q == CRXF_DATA)
      begin
        pos_q <= pos_q + 10'h001; // data bits only
        shift_q <= {bit_q, shift_q[7:1]};
        bit_cnt_q <= bit_cnt_q + 3'h1;
        if (bit_cnt_q == 3'h7)
          state_q <= CRXF_PARITY;
      end
      else if (state_q == CRXF_PARITY)
      begin
        state_q <= CRXF_DATA; // parity bit dropped
        crc_q <= crc_byte(crc_q, shift_q);
        pend_q[1] <= pend_q[0];
        pend_q[0] <= shift_q;
        if (pend_cnt_q != 2'h2)
          pend_cnt_q <= pend_cnt_q + 2'h1;
      end
    end
  end
  assign push = bit_clk_q && state_q == CRXF_PARITY && pend_cnt_q == 2'h2
                && count_q != 5'(FIFO_DEPTH);
  assign push_data = pend_q[1];

  // receive fifo storage, needs no reset
  always_ff @(posedge clk)
  begin
    if (push)
      fifo[wr_ptr_q] <= push_data;
  end

  // receive fifo pointers and count
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_q <= 4'h0;
      rd_ptr_q <= 4'h0;
      count_q <= 5'h00;
    end
    else
    begin
      if (push)
        wr_ptr_q <= ptr_inc(wr_ptr_q);
      if (pop)
        rd_ptr_q <= ptr_inc(rd_ptr_q);
      count_q <= count_q + 5'(push) - 5'(pop);
    end
  end

  //----------------------------------------------------------------------------
  // collision and signal strength capture
  //----------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      coll_low_q <= 8'h00;
      coll_high_q <= 8'h00;
      strength_q <= 8'h00;
    end
    else
    begin
      if (coll_hit && !protocol_q[CRXF_BIT_TYPE_B])
      begin
        coll_low_q <= pos_q[7:0];
        coll_high_q[7:6] <= pos_q[9:8];
      end
      if (wr_access && avs_address == CRXF_ADDR_COLL_HIGH)
        coll_high_q[5:0] <= avs_writedata[5:0];
      if (eof_ok)
        strength_q <= {2'h1, strength_aux, strength_main};
    end
  end

  //----------------------------------------------------------------------------
  // interrupt flags: set wins over clear-on-read
  //----------------------------------------------------------------------------
  logic [7:0] set_vec;
  logic flags_rd;
  logic crc_bad;
  logic fifo_warn;
  assign crc_bad = eof_ok && crc_q != 16'h0000;
  assign fifo_warn = push && count_q == 5'(CRXF_FIFO_WARN - 1);
  assign flags_rd = rd_access && avs_address == CRXF_ADDR_IRQ_FLAGS;

  always_comb
  begin
    set_vec = 8'h00;
    set_vec[CRXF_IRQ_SOF] = sof_ok;
    set_vec[CRXF_IRQ_RX_END] = eof_ok;
    set_vec[CRXF_IRQ_FIFO] = fifo_warn;
    set_vec[CRXF_IRQ_ERR_PAR] = par_err;
    set_vec[CRXF_IRQ_ERR_CRC] = crc_bad;
    set_vec[CRXF_IRQ_ERR_FRM] = eof_ok && bit_cnt_q != 3'h0;
    set_vec[CRXF_IRQ_COLL] = coll_hit;
    set_vec[CRXF_IRQ_NORESP] = nr_expire;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      irq_flags_q <= 8'h00;
    else
      irq_flags_q <= (flags_rd ? 8'h00 : irq_flags_q) | set_vec;
  end

  // request line: level for every flag not masked by coll_high_q, cleared by flag read
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      irq <= 1'b0;
    else
      irq <= |(irq_flags_q & ~coll_high_q) & !flags_rd;
  end

  //----------------------------------------------------------------------------
  // read data
  //----------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      avs_readdata <= 32'h0000_0000;
    else if (rd_access)
    begin
      unique case (avs_address)
        CRXF_ADDR_CHIP_STATE: avs_readdata <= {24'h0, chip_state_q};
        CRXF_ADDR_PROTOCOL: avs_readdata <= {24'h0, protocol_q};
        CRXF_ADDR_NO_RESP: avs_readdata <= {24'h0, no_resp_q};
        CRXF_ADDR_RX_WAIT: avs_readdata <= {24'h0, rx_wait_q};
        CRXF_ADDR_FILTER_GAIN: avs_readdata <= {24'h0, filter_q};
        CRXF_ADDR_IRQ_FLAGS: avs_readdata <= {24'h0, irq_flags_q};
        CRXF_ADDR_COLL_HIGH: avs_readdata <= {24'h0, coll_high_q};
        CRXF_ADDR_COLL_LOW: avs_readdata <= {24'h0, coll_low_q};
        CRXF_ADDR_STRENGTH: avs_readdata <= {24'h0, strength_q};
        CRXF_ADDR_FIFO_STATE: avs_readdata <= {27'h0, count_q};
        CRXF_ADDR_FIFO_DATA: avs_readdata <= {24'h0, fifo[rd_ptr_q]};
        default: avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule
`default_nettype wire

// ===== include/crxf_pkg.sv
//------------------------------------------------------------------------------
// Summary of operation
//------------------------------------------------------------------------------
// Summary of operation
// - swap bit clear routes input one to main receiver, set swaps inputs
// - only the main receiver feeds the digitizer and decoding logic
// - both receivers' signal strength values are stored for host readback
// - filter settings follow protocol selection, host may fine-tune afterwards
// - bits 7..4 pick band-pass ranges, all zero gives default band
// - bits 3:2 set digital gain reduction, bits 1:0 reserved
// - bit decoder turns subcarrier into bits with clock, tolerating glitches
// - framer builds bytes and strips frame and communication symbols
// - parity and crc are checked and dropped, payload goes to 12-byte fifo
// - a good start of frame sets flags in interrupt status
// - end of receive drives interrupt request high
// - interrupt raised when fifo reaches 75 percent while receiving
// - framing, parity or crc errors hold interrupt until flags are read and record cause
// - each protocol write reloads presets of related registers
// - bit collision raises interrupt and sets collision flag
// - type a collision position split over low register and bits 7:6
// - collision position counts from zero after start bit
// - decoders held in reset for wait value times 9.44 us after transmit
// - protocol write presets receive wait to minimum tag response time
// - no-response timer from slot start, value times 37.76 us, preset
package crxf_pkg;

  //----------------------------------------------------------------------------
  // register offsets (word addresses, one word each)
  //----------------------------------------------------------------------------
  localparam logic [7:0] CRXF_ADDR_CHIP_STATE = 8'h00;
  localparam logic [7:0] CRXF_ADDR_PROTOCOL = 8'h01;
  localparam logic [7:0] CRXF_ADDR_NO_RESP = 8'h07;
  localparam logic [7:0] CRXF_ADDR_RX_WAIT = 8'h08;
  localparam logic [7:0] CRXF_ADDR_FILTER_GAIN = 8'h0A;
  localparam logic [7:0] CRXF_ADDR_IRQ_FLAGS = 8'h0C;
  localparam logic [7:0] CRXF_ADDR_COLL_HIGH = 8'h0D;
  localparam logic [7:0] CRXF_ADDR_COLL_LOW = 8'h0E;
  localparam logic [7:0] CRXF_ADDR_STRENGTH = 8'h0F;
  localparam logic [7:0] CRXF_ADDR_FIFO_STATE = 8'h1C;
  localparam logic [7:0] CRXF_ADDR_FIFO_DATA = 8'h1F;

  //----------------------------------------------------------------------------
  // field positions
  //----------------------------------------------------------------------------
  localparam int CRXF_BIT_SWAP = 3;
  localparam int CRXF_BIT_TYPE_B = 0;
  localparam int CRXF_IRQ_FIFO = 6;
  localparam int CRXF_IRQ_RX_END = 5;
  localparam int CRXF_IRQ_SOF = 4;
  localparam int CRXF_IRQ_COLL = 1;
  localparam int CRXF_IRQ_NORESP = 0;
  localparam int CRXF_IRQ_ERR_CRC = 3;
  localparam int CRXF_IRQ_ERR_PAR = 2;
  localparam int CRXF_IRQ_ERR_FRM = 7;

  //----------------------------------------------------------------------------
  // reset values and protocol presets
  //----------------------------------------------------------------------------
  localparam logic [7:0] CRXF_RST_CHIP_STATE = 8'h00;
  localparam logic [7:0] CRXF_RST_PROTOCOL = 8'h00;
  localparam logic [7:0] CRXF_PRE_A_FILTER = 8'h20;
  localparam logic [7:0] CRXF_PRE_B_FILTER = 8'h00;
  localparam logic [7:0] CRXF_PRE_A_RX_WAIT = 8'h0E;
  localparam logic [7:0] CRXF_PRE_B_RX_WAIT = 8'h1F;
  localparam logic [7:0] CRXF_PRE_A_NO_RESP = 8'h0E;
  localparam logic [7:0] CRXF_PRE_B_NO_RESP = 8'h15;
  localparam logic [1:0] CRXF_RESERVED_MASK = 2'h0;

  //----------------------------------------------------------------------------
  // timing
  //----------------------------------------------------------------------------
  localparam int CRXF_CLK_KHZ = 40000;
  localparam int CRXF_RX_WAIT_NS = 9440;
  localparam int CRXF_NO_RESP_NS = 37760;
  localparam int CRXF_RX_WAIT_CYC = CRXF_RX_WAIT_NS * CRXF_CLK_KHZ / 1000000;
  localparam int CRXF_NO_RESP_CYC = CRXF_NO_RESP_NS * CRXF_CLK_KHZ / 1000000;
  localparam int CRXF_FIFO_DEPTH = 12;
  localparam int CRXF_FIFO_WARN = CRXF_FIFO_DEPTH * 3 / 4;
  localparam int CRXF_COLL_FIRST = 16;

endpackage

// ===== test/crxf_sva.sv
`timescale 1ns/1ps
`default_nettype none
module crxf_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic rf_input_one,
  input wire logic rf_input_two,
  input wire logic main_rx_out,
  input wire logic aux_rx_out,
  input wire logic [3:0] band_select,
  input wire logic [1:0] gain_reduce,
  input wire logic irq
);
  import crxf_pkg::*;
  logic req;
  logic acc;
  // request and accepting edge seen on the bus
  assign req = avs_read | avs_write;
  assign acc = req & !avs_waitrequest;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  //----------------------------------------------------------------------------
  // bus handshake and routing
  //----------------------------------------------------------------------------
  wait_one_a: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered in one cycle");
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  rd_upper_a: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 0)
    else $error("upper read bits not zero");
  unmapped_rd_a: assert property (acc && avs_read && avs_address == 8'h02
    |-> avs_readdata == 0) else $error("unmapped read not zero");
  same_route_a: assert property (rf_input_one == rf_input_two |=>
    main_rx_out == $past(rf_input_one) && aux_rx_out == main_rx_out)
    else $error("routed copies wrong");
  diff_route_a: assert property (main_rx_out != aux_rx_out |->
    $past(rf_input_one != rf_input_two)) else $error("routing invented");
  filt_write_a: assert property (acc && avs_write
    && avs_address == CRXF_ADDR_FILTER_GAIN |-> ##2
    {band_select, gain_reduce} == $past(avs_writedata[7:2], 2))
    else $error("filter fields not applied");
  proto_preset_a: assert property (acc && avs_write
    && avs_address == CRXF_ADDR_PROTOCOL |-> ##2 band_select ==
    ($past(avs_writedata[0], 2) ? CRXF_PRE_B_FILTER[7:4]
    : CRXF_PRE_A_FILTER[7:4])) else $error("filter preset wrong");
  flag_read_a: assert property (acc && avs_read
    && avs_address == CRXF_ADDR_IRQ_FLAGS |=> !irq)
    else $error("irq stays after flag read");
endmodule
bind crxf_top crxf_chk chk (.clk(clk), .rst_n(rst_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .rf_input_one(rf_input_one),
  .rf_input_two(rf_input_two), .main_rx_out(main_rx_out),
  .aux_rx_out(aux_rx_out), .band_select(band_select),
  .gain_reduce(gain_reduce), .irq(irq));
`default_nettype wire

// ===== test/crxf_tag_model.sv
`timescale 1ns/1ps
`default_nettype none
module crxf_tag_model (
  input wire logic clk,
  output logic frame_sof,
  output logic frame_eof,
  output logic frame_bit,
  output logic tx_done,
  output logic slot_start
);
  logic [7:0] pay [16];
  logic busy = 1'b0;
  initial
  begin
    {frame_sof, frame_eof, tx_done, slot_start} = 4'h0;
    frame_bit = 1'b0;
  end
  // idle line toggles each cycle, too short to pass as a bit
  always @(posedge clk)
    if (!busy)
      frame_bit <= ~frame_bit;
  // one-cycle pulse on sof, eof, tx_done, slot_start
  task automatic pulse(input logic [3:0] v);
    @(posedge clk);
    {frame_sof, frame_eof, tx_done, slot_start} <= v;
    @(posedge clk);
    {frame_sof, frame_eof, tx_done, slot_start} <= 4'h0;
  endtask
  // short inverted glitch first, so equal bits still show a change
  task automatic put_bit(input logic b);
    @(posedge clk);
    frame_bit <= ~b;
    repeat (4) @(posedge clk) frame_bit <= b;
  endtask
  // mode 0 good, 1 parity error, 2 crc error, 3 collision at bit 16
  task automatic send(input int n, input int mode);
    logic [15:0] c;
    logic [7:0] b;
    busy = 1'b1;
    c = 16'hFFFF;
    for (int i = 0; i < n; i++)
    begin
      c = c ^ {8'h00, pay[i]};
      for (int j = 0; j < 8; j++)
        c = c[0] ? (c >> 1) ^ 16'h8408 : c >> 1;
    end
    pay[n] = c[7:0] ^ ((mode == 2) ? 8'h01 : 8'h00);
    pay[n + 1] = c[15:8];
    pulse(4'h8);
    for (int i = 0; i < n + 2; i++)
    begin
      if (mode == 3 && i == 2)
        pulse(4'hC);
      b = pay[i];
      for (int k = 0; k < 8; k++)
        put_bit(b[k]);
      put_bit(~^b ^ (mode == 1 && i == 0));
    end
    pulse(4'h4);
    busy = 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== test/crxf_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module crxf_top_tb;
  import crxf_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic rf_one = 1'b0;
  logic rf_two = 1'b0;
  logic tx_done, slot_start, sof, eof, fbit, main_o, aux_o, irq;
  logic [3:0] band;
  logic [1:0] gain;
  logic [7:0] q;
  logic [7:0] eb [4] = '{8'h00, 8'h04, 8'h08, 8'h02};
  int n_fail = 0;
  int num_checks = 0;
  // write flag, address, write data, expected read
  logic [24:0] rows [16] = '{25'h0000000, 25'h0010000, 25'h00A0020,
    25'h008000E, 25'h007000E, 25'h0020000, 25'h1010100, 25'h00A0000,
    25'h008001F, 25'h0070015, 25'h10AFF00, 25'h00A00FC, 25'h1010000,
    25'h00A0020, 25'h1025500, 25'h0020000};
  always #12.5 clk = ~clk;
  crxf_top uut (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rf_input_one(rf_one),
    .rf_input_two(rf_two), .strength_main(3'h5), .strength_aux(3'h2),
    .tx_done(tx_done), .slot_start(slot_start), .frame_sof(sof),
    .frame_eof(eof), .frame_bit(fbit), .main_rx_out(main_o),
    .aux_rx_out(aux_o), .band_select(band), .gain_reduce(gain), .irq(irq));
  crxf_tag_model tag (.clk(clk), .frame_sof(sof), .frame_eof(eof),
    .frame_bit(fbit), .tx_done(tx_done), .slot_start(slot_start));
  //----------------------------------------------------------------------------
  // shared tasks
  //----------------------------------------------------------------------------
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // one bus cycle, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int t;
    t = 0;
    @(posedge clk);
    avs_address <= a;
    avs_read <= !w;
    avs_write <= w;
    avs_writedata <= {24'h0, d};
    do
    begin
      @(posedge clk);
      t++;
    end
    while (avs_waitrequest !== 1'b0 && t < 20);
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0)
    begin
      n_fail++;
      end_of_test;
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(q, e);
  endtask
  // count first, then pop exactly that many bytes
  task automatic drain;
    logic [7:0] n;
    bus(1'b0, CRXF_ADDR_FIFO_STATE, 8'h00);
    n = q & 8'h1F;
    repeat (n) bus(1'b0, CRXF_ADDR_FIFO_DATA, 8'h00);
  endtask
  // bounded wait for the request line
  task automatic wait_irq;
    for (int t = 0; t < 2000 && irq !== 1'b1; t++)
      @(posedge clk);
    if (irq !== 1'b1)
    begin
      n_fail++;
      end_of_test;
    end
  endtask
  task automatic frame(input int n, input int mode);
    for (int i = 0; i < n; i++)
      tag.pay[i] = 8'(8'h11 * (i + 1));
    tag.send(n, mode);
    wait_irq;
  endtask
  //----------------------------------------------------------------------------
  // main sequence
  //----------------------------------------------------------------------------
  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i])
      if (rows[i][24])
        bus(1'b1, rows[i][23:16], rows[i][15:8]);
      else
        rd(rows[i][23:16], rows[i][7:0]);
    $display("register table done");
    for (int g = 0; g < 4; g++)
    begin
      bus(1'b1, CRXF_ADDR_FILTER_GAIN, 8'((8'h10 << g) | (g << 2)));
      repeat (2) @(posedge clk);
      chk({4'h0, band}, 8'(8'h01 << g));
      chk({6'h0, gain}, 8'(g));
    end
    rf_one <= 1'b1;
    repeat (3) @(posedge clk);
    chk({main_o, aux_o, 6'h0}, 8'h80);
    bus(1'b1, CRXF_ADDR_CHIP_STATE, 8'h08);
    repeat (3) @(posedge clk);
    chk({main_o, aux_o, 6'h0}, 8'h40);
    $display("filter and routing done");
    frame(3, 0);
    rd(CRXF_ADDR_FIFO_STATE, 8'h03);
    for (int i = 0; i < 3; i++)
      rd(CRXF_ADDR_FIFO_DATA, 8'(8'h11 * (i + 1)));
    rd(CRXF_ADDR_IRQ_FLAGS, 8'h30);
    rd(CRXF_ADDR_STRENGTH, 8'h55);
    chk({7'h0, irq}, 8'h00);
    frame(10, 0);
    rd(CRXF_ADDR_IRQ_FLAGS, 8'h70);
    drain;
    for (int m = 1; m < 4; m++)
    begin
      frame(4, m);
      bus(1'b0, CRXF_ADDR_IRQ_FLAGS, 8'h00);
      chk(q & eb[m], eb[m]);
      drain;
    end
    rd(CRXF_ADDR_COLL_LOW, 8'h10);
    bus(1'b0, CRXF_ADDR_COLL_HIGH, 8'h00);
    chk(q & 8'hC0, 8'h00);
    $display("frames done");
    bus(1'b1, CRXF_ADDR_RX_WAIT, 8'h01);
    tag.pulse(4'h2);
    tag.send(2, 0);
    repeat (300) @(posedge clk);
    rd(CRXF_ADDR_IRQ_FLAGS, 8'h00);
    frame(2, 0);
    rd(CRXF_ADDR_IRQ_FLAGS, 8'h30);
    drain;
    bus(1'b1, CRXF_ADDR_NO_RESP, 8'h01);
    tag.pulse(4'h1);
    repeat (1400) @(posedge clk);
    rd(CRXF_ADDR_IRQ_FLAGS, 8'h00);
    wait_irq;
    rd(CRXF_ADDR_IRQ_FLAGS, 8'h01);
    $display("timers done");
    end_of_test;
  end
endmodule
`default_nettype wire
